// [core/utc_modular_clock_core.sv]
// Time-of-day clock core: UTC time, day, year, sidereal rate, sync and pps.
// Assumes osc_1mhz and ref_pps are already synchronous to core_clk, and an
// Avalon-MM master that holds its request while waitrequest is high.
//
// What this block does
// - Every time rate comes from edges of the 1 MHz oscillator input.
// - Sidereal generator turns 1 MHz into a 1.002737xxx MHz pulse train.
// - Operator sets the last three rate digits; 909 after reset.
// - Day of year counts 0..365, or 0..366 in a leap year; settable.
// - Year keeps units and tens digits, each set by its own control.
// - Five advance controls step time by 100ms, 10ms, 1ms, 100us, 10us.
// - Five retard controls step time back by the same amounts.
// - Stop control halts the 10 us ticks; an armed sync and the sidereal count still run.
// - With sync armed, the second boundary snaps to the reference pulse.
// - Leap year and leap second are preset beforehand, applied on event.
// - Core emits its own 1 ms pulse each second for drift monitoring.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module utc_modular_clock_core (
	input  wire logic                     core_clk,
	input  wire logic                     srst,
	input  wire logic                     osc_1mhz,
	input  wire logic                     ref_pps,
	input  wire utc_clock_pkg::avmm_req_t av_req,
	output utc_clock_pkg::avmm_resp_t     av_resp,
	output logic                          pps_out,
	output logic                          sidereal_pulse
);

	// ==========================================================
	// Calendar stepping
	function automatic utc_clock_pkg::clk_time_t step_up(
		input utc_clock_pkg::clk_time_t t,
		input logic                     insert,
		input logic [8:0]               last
	);
		utc_clock_pkg::clk_time_t r;
		r = t;
		if (insert && t.sec == utc_clock_pkg::SEC_LAST) begin
			r.sec = utc_clock_pkg::SEC_LEAP;
		end else if (t.sec < utc_clock_pkg::SEC_LAST) begin
			r.sec = t.sec + 6'h01;
		end else begin
			r.sec = 6'h00;
			if (t.min < utc_clock_pkg::MIN_LAST) begin
				r.min = t.min + 6'h01;
			end else begin
				r.min = 6'h00;
				if (t.hour < utc_clock_pkg::HOUR_LAST) begin
					r.hour = t.hour + 5'h01;
				end else begin
					r.hour = 5'h00;
					if (t.day < last) begin
						r.day = t.day + 9'h001;
					end else begin
						r.day = 9'h000;
						if (t.units < utc_clock_pkg::DIGIT_LAST) begin
							r.units = t.units + 4'h1;
						end else begin
							r.units = 4'h0;
							r.tens  = (t.tens < utc_clock_pkg::DIGIT_LAST) ? t.tens + 4'h1 : 4'h0;
						end
					end
				end
			end
		end
		return r;
	endfunction

	// Borrowing below day 0 wraps to the last day; the year is not touched
	function automatic utc_clock_pkg::clk_time_t step_down(
		input utc_clock_pkg::clk_time_t t,
		input logic [8:0]               last
	);
		utc_clock_pkg::clk_time_t r;
		r = t;
		if (t.sec != 6'h00) begin
			r.sec = t.sec - 6'h01;
		end else begin
			r.sec = utc_clock_pkg::SEC_LAST;
			if (t.min != 6'h00) begin
				r.min = t.min - 6'h01;
			end else begin
				r.min = utc_clock_pkg::MIN_LAST;
				if (t.hour != 5'h00) begin
					r.hour = t.hour - 5'h01;
				end else begin
					r.hour = utc_clock_pkg::HOUR_LAST;
					r.day  = (t.day != 9'h000) ? t.day - 9'h001 : last;
				end
			end
		end
		return r;
	endfunction

	// ==========================================================
	// State
	utc_clock_pkg::clock_state_t st_q;
	utc_clock_pkg::clock_state_t st_d;
	logic                        osc_rise;
	logic                        ref_rise;
	logic                        tick;
	logic                        wr_hit;
	logic                        rd_take;
	logic                        leap_now;
	logic [8:0]                  day_last;
	logic [29:0]                 sid_sum;
	logic [31:0]                 wd;

	always_comb begin
		st_d     = st_q;
		wd       = av_req.writedata;
		osc_rise = osc_1mhz & ~st_q.osc_prev;
		ref_rise = ref_pps & ~st_q.ref_prev;
		wr_hit   = av_req.write & st_q.ack;
		rd_take  = av_req.read & ~st_q.ack;
		day_last = st_q.leap_year ? utc_clock_pkg::DAY_LAST_LEAP : utc_clock_pkg::DAY_LAST;
		sid_sum  = st_q.sid_acc + utc_clock_pkg::SID_FRAC_BASE + 30'(st_q.rate_lsd);
		tick     = 1'b0;
		leap_now = 1'b0;

		st_d.osc_prev = osc_1mhz;
		st_d.ref_prev = ref_pps;
		st_d.ack      = (av_req.read | av_req.write) & ~st_q.ack;

		// ======================================================
		// Register writes
		if (wr_hit) begin
			unique case (av_req.address)
				utc_clock_pkg::REG_CTRL: begin
					st_d.stop     = wd[utc_clock_pkg::CTRL_STOP];
					st_d.sync_arm = wd[utc_clock_pkg::CTRL_SYNC_ARM];
				end
				utc_clock_pkg::REG_RATE: begin
					// Out-of-range digit settings are ignored
					if (wd[9:0] <= utc_clock_pkg::RATE_LSD_MAX) begin
						st_d.rate_lsd = wd[9:0];
					end
				end
				utc_clock_pkg::REG_LEAP: begin
					st_d.leap_year    = wd[utc_clock_pkg::LEAP_YEAR];
					st_d.leap_sec_arm = wd[utc_clock_pkg::LEAP_SEC_ARM];
					st_d.leap_day     = wd[utc_clock_pkg::LEAP_DAY_LSB +: 9];
				end
				utc_clock_pkg::REG_SET_TIME: begin
					st_d.set_hour = wd[utc_clock_pkg::TIME_HOUR_LSB +: 5];
					st_d.set_min  = wd[utc_clock_pkg::TIME_MIN_LSB +: 6];
					st_d.set_sec  = wd[utc_clock_pkg::TIME_SEC_LSB +: 6];
				end
				utc_clock_pkg::REG_SET_DAY: begin
					st_d.set_day = wd[8:0];
				end
				utc_clock_pkg::REG_STATUS: begin
					if (wd[utc_clock_pkg::STAT_SYNCED]) begin
						st_d.synced = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// ======================================================
		// Time keeping in 10 us units from the 1 MHz input
		if (osc_rise) begin
			st_d.div = (st_q.div == utc_clock_pkg::TICK_DIV_LAST) ? 4'h0 : st_q.div + 4'h1;
			tick     = (st_q.div == utc_clock_pkg::TICK_DIV_LAST) & ~st_q.stop;
		end
		leap_now = st_q.leap_sec_arm && st_q.tm.day == st_q.leap_day &&
			st_q.tm.hour == utc_clock_pkg::HOUR_LAST && st_q.tm.min == utc_clock_pkg::MIN_LAST;
		if (tick) begin
			if (st_q.subsec == utc_clock_pkg::SUBSEC_LAST) begin
				st_d.subsec = 17'h00000;
				st_d.tm     = step_up(st_q.tm, leap_now, day_last);
			end else begin
				st_d.subsec = st_q.subsec + 17'h00001;
			end
		end

		// Round to the nearest second so a small lead or lag never slips a second
		if (st_q.sync_arm && ref_rise) begin
			if (st_q.subsec >= utc_clock_pkg::SUBSEC_HALF) begin
				st_d.tm = step_up(st_q.tm, leap_now, day_last);
			end else begin
				st_d.tm = st_q.tm;
			end
			st_d.subsec = 17'h00000;
			st_d.div    = 4'h0;
			st_d.synced = 1'b1;
		end

		// ======================================================
		// Command pulses act on the already advanced time
		if (wr_hit && av_req.address == utc_clock_pkg::REG_CMD) begin
			for (int i = 0; i < 5; i++) begin
				if (wd[utc_clock_pkg::CMD_ADV_LSB + i]) begin
					if (st_d.subsec + utc_clock_pkg::STEP[i] >= utc_clock_pkg::SUBSEC_WRAP) begin
						st_d.subsec = st_d.subsec + utc_clock_pkg::STEP[i] - utc_clock_pkg::SUBSEC_WRAP;
						// Stepping across the designated minute still inserts the leap second
						st_d.tm     = step_up(st_d.tm, st_q.leap_sec_arm &&
							st_d.tm.day == st_q.leap_day &&
							st_d.tm.hour == utc_clock_pkg::HOUR_LAST &&
							st_d.tm.min == utc_clock_pkg::MIN_LAST, day_last);
					end else begin
						st_d.subsec = st_d.subsec + utc_clock_pkg::STEP[i];
					end
				end
				if (wd[utc_clock_pkg::CMD_RET_LSB + i]) begin
					if (st_d.subsec < utc_clock_pkg::STEP[i]) begin
						st_d.subsec = st_d.subsec + utc_clock_pkg::SUBSEC_WRAP - utc_clock_pkg::STEP[i];
						st_d.tm     = step_down(st_d.tm, day_last);
					end else begin
						st_d.subsec = st_d.subsec - utc_clock_pkg::STEP[i];
					end
				end
			end
			if (wd[utc_clock_pkg::CMD_LOAD_TIME]) begin
				st_d.tm.hour = st_q.set_hour;
				st_d.tm.min  = st_q.set_min;
				st_d.tm.sec  = st_q.set_sec;
				st_d.subsec  = 17'h00000;
			end
			if (wd[utc_clock_pkg::CMD_LOAD_DAY]) begin
				st_d.tm.day = (st_q.set_day > day_last) ? day_last : st_q.set_day;
			end
			if (wd[utc_clock_pkg::CMD_YR_UNITS]) begin
				st_d.tm.units = (st_d.tm.units < utc_clock_pkg::DIGIT_LAST) ? st_d.tm.units + 4'h1 : 4'h0;
			end
			if (wd[utc_clock_pkg::CMD_YR_TENS]) begin
				st_d.tm.tens = (st_d.tm.tens < utc_clock_pkg::DIGIT_LAST) ? st_d.tm.tens + 4'h1 : 4'h0;
			end
		end

		// Presets are consumed once the event has happened
		if (st_d.tm.sec == utc_clock_pkg::SEC_LEAP && st_q.tm.sec != utc_clock_pkg::SEC_LEAP) begin
			st_d.leap_sec_arm = 1'b0;
		end
		if (st_q.tm.day == day_last && st_d.tm.day == 9'h000 && st_q.tm.hour == utc_clock_pkg::HOUR_LAST) begin
			st_d.leap_year = 1'b0;
		end

		st_d.pps = st_d.subsec < utc_clock_pkg::PPS_TICKS;

		// ======================================================
		// Sidereal rate: one pulse per input edge plus a fractional extra
		st_d.sid_extra = 1'b0;
		if (osc_rise) begin
			if (sid_sum >= utc_clock_pkg::SID_FRAC_MOD) begin
				st_d.sid_acc   = sid_sum - utc_clock_pkg::SID_FRAC_MOD;
				st_d.sid_extra = 1'b1;
			end else begin
				st_d.sid_acc = sid_sum;
			end
		end
		// Extra pulse lands one core cycle after the edge's own pulse, two after the edge; edges are 40 cycles apart
		st_d.sid_pulse = osc_rise | st_q.sid_extra;
		if (st_q.sid_pulse) begin
			if (st_q.sid_us == utc_clock_pkg::SID_US_LAST) begin
				st_d.sid_us  = 20'h00000;
				st_d.sid_sec = (st_q.sid_sec == utc_clock_pkg::SID_SEC_LAST) ? 17'h00000 : st_q.sid_sec + 17'h00001;
			end else begin
				st_d.sid_us = st_q.sid_us + 20'h00001;
			end
		end

		// ======================================================
		// Read data, captured one cycle before waitrequest drops
		if (rd_take) begin
			unique case (av_req.address)
				utc_clock_pkg::REG_CTRL:     st_d.rdata = {30'h0, st_q.sync_arm, st_q.stop};
				utc_clock_pkg::REG_RATE:     st_d.rdata = {22'h0, st_q.rate_lsd};
				utc_clock_pkg::REG_LEAP:     st_d.rdata = {7'h0, st_q.leap_day, 14'h0, st_q.leap_sec_arm, st_q.leap_year};
				utc_clock_pkg::REG_SET_TIME: st_d.rdata = {11'h0, st_q.set_hour, 2'h0, st_q.set_min, 2'h0, st_q.set_sec};
				utc_clock_pkg::REG_SET_DAY:  st_d.rdata = {23'h0, st_q.set_day};
				utc_clock_pkg::REG_TIME:     st_d.rdata = {11'h0, st_q.tm.hour, 2'h0, st_q.tm.min, 2'h0, st_q.tm.sec};
				utc_clock_pkg::REG_DATE:     st_d.rdata = {8'h0, st_q.tm.tens, st_q.tm.units, 7'h0, st_q.tm.day};
				utc_clock_pkg::REG_SUBSEC:   st_d.rdata = {15'h0, st_q.subsec};
				utc_clock_pkg::REG_SIDEREAL: st_d.rdata = {15'h0, st_q.sid_sec};
				utc_clock_pkg::REG_STATUS:   st_d.rdata = {29'h0, st_q.leap_year, st_q.leap_sec_arm, st_q.synced};
				default:                     st_d.rdata = 32'h0;
			endcase
		end

		if (srst) begin
			st_d          = '0;
			st_d.rate_lsd = utc_clock_pkg::RATE_LSD_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	// One driver for the whole response word
	assign av_resp             = '{waitrequest: (av_req.read | av_req.write) & ~st_q.ack,
		readdata: st_q.rdata};
	assign pps_out             = st_q.pps;
	assign sidereal_pulse      = st_q.sid_pulse;

endmodule

`default_nettype wire

// [core/utc_clock_pkg.sv]
// Constants, register map and carrier types for the time-of-day clock core.
// Assumes a 40 MHz core clock and a 1 MHz oscillator input sampled on it.
package utc_clock_pkg;

	// ==========================================================
	// Timing
	localparam int OSC_MHZ      = 1;
	localparam int TICK_US      = 10;
	localparam int PPS_WIDTH_US = 1000;
	localparam logic [3:0]  TICK_DIV_LAST = 4'(TICK_US * OSC_MHZ - 1);
	localparam logic [16:0] PPS_TICKS     = 17'(PPS_WIDTH_US / TICK_US);
	localparam logic [16:0] SUBSEC_LAST   = 17'h1869f;
	localparam logic [16:0] SUBSEC_WRAP   = 17'h186a0;
	localparam logic [16:0] SUBSEC_HALF   = 17'h0c350;
	// Steps in 10 us units: index 0 is 100 ms, index 4 is 10 us
	localparam logic [4:0][16:0] STEP = {17'h00001, 17'h0000a, 17'h00064, 17'h003e8, 17'h02710};

	// ==========================================================
	// Calendar limits
	localparam logic [5:0] SEC_LAST      = 6'h3b;
	localparam logic [5:0] SEC_LEAP      = 6'h3c;
	localparam logic [5:0] MIN_LAST      = 6'h3b;
	localparam logic [4:0] HOUR_LAST     = 5'h17;
	localparam logic [8:0] DAY_LAST      = 9'h16d;
	localparam logic [8:0] DAY_LAST_LEAP = 9'h16e;
	localparam logic [3:0] DIGIT_LAST    = 4'h9;

	// ==========================================================
	// Sidereal rate generator
	localparam logic [29:0] SID_FRAC_BASE = 30'h029c368;
	localparam logic [29:0] SID_FRAC_MOD  = 30'h3b9aca00;
	localparam logic [9:0]  RATE_LSD_RST  = 10'h38d;
	localparam logic [9:0]  RATE_LSD_MAX  = 10'h3e7;
	localparam logic [19:0] SID_US_LAST   = 20'hf423f;
	localparam logic [16:0] SID_SEC_LAST  = 17'h1517f;

	// ==========================================================
	// Register byte offsets
	localparam logic [5:0] REG_CTRL     = 6'h00;
	localparam logic [5:0] REG_RATE     = 6'h04;
	localparam logic [5:0] REG_LEAP     = 6'h08;
	localparam logic [5:0] REG_CMD      = 6'h0c;
	localparam logic [5:0] REG_SET_TIME = 6'h10;
	localparam logic [5:0] REG_SET_DAY  = 6'h14;
	localparam logic [5:0] REG_TIME     = 6'h18;
	localparam logic [5:0] REG_DATE     = 6'h1c;
	localparam logic [5:0] REG_SUBSEC   = 6'h20;
	localparam logic [5:0] REG_SIDEREAL = 6'h24;
	localparam logic [5:0] REG_STATUS   = 6'h28;

	// ==========================================================
	// Field positions
	localparam int CTRL_STOP     = 0;
	localparam int CTRL_SYNC_ARM = 1;
	localparam int LEAP_YEAR     = 0;
	localparam int LEAP_SEC_ARM  = 1;
	localparam int LEAP_DAY_LSB  = 16;
	localparam int CMD_ADV_LSB   = 0;
	localparam int CMD_RET_LSB   = 5;
	localparam int CMD_LOAD_TIME = 10;
	localparam int CMD_LOAD_DAY  = 11;
	localparam int CMD_YR_UNITS  = 12;
	localparam int CMD_YR_TENS   = 13;
	localparam int TIME_SEC_LSB  = 0;
	localparam int TIME_MIN_LSB  = 8;
	localparam int TIME_HOUR_LSB = 16;
	localparam int DATE_UNITS_LSB = 16;
	localparam int DATE_TENS_LSB  = 20;
	localparam int STAT_SYNCED   = 0;
	localparam int STAT_LEAP_SEC = 1;
	localparam int STAT_LEAP_YR  = 2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} avmm_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} avmm_resp_t;

	typedef struct packed {
		logic [3:0] tens;
		logic [3:0] units;
		logic [8:0] day;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} clk_time_t;

	typedef struct packed {
		logic        osc_prev;
		logic        ref_prev;
		logic [3:0]  div;
		logic [16:0] subsec;
		clk_time_t   tm;
		logic        stop;
		logic        sync_arm;
		logic        synced;
		logic [9:0]  rate_lsd;
		logic        leap_year;
		logic        leap_sec_arm;
		logic [8:0]  leap_day;
		logic [4:0]  set_hour;
		logic [5:0]  set_min;
		logic [5:0]  set_sec;
		logic [8:0]  set_day;
		logic [29:0] sid_acc;
		logic        sid_extra;
		logic        sid_pulse;
		logic [19:0] sid_us;
		logic [16:0] sid_sec;
		logic        pps;
		logic        ack;
		logic [31:0] rdata;
	} clock_state_t;

endpackage

// [dv/utc_clock_core_sva.sv]
// Port assertions for the time-of-day clock core.
// Assumes it is attached by the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module utc_clock_core_sva (
	input wire logic                      core_clk,
	input wire logic                      srst,
	input wire logic                      osc_1mhz,
	input wire logic                      ref_pps,
	input wire utc_clock_pkg::avmm_req_t  av_req,
	input wire utc_clock_pkg::avmm_resp_t av_resp,
	input wire logic                      pps_out,
	input wire logic                      sidereal_pulse
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	logic rq;
	logic wt;
	logic rd_ok;
	assign rq    = av_req.read | av_req.write;
	assign wt    = av_resp.waitrequest;
	assign rd_ok = av_req.read & ~wt;

	// ==========================================================
	// Register bus
	one_wait_a: assert property (rq && wt |=> !wt)
		else $error("waitrequest not released after one cycle");
	rearm_a: assert property (rq && !wt |=> wt == rq)
		else $error("waitrequest not raised for next access");
	idle_wait_a: assert property (!rq |-> !wt)
		else $error("waitrequest high with no access");
	unmapped_a: assert property (rd_ok && av_req.address == 6'h3c |-> av_resp.readdata == 32'h0)
		else $error("unmapped read not zero");
	cmd_zero_a: assert property (rd_ok && av_req.address == utc_clock_pkg::REG_CMD
		|-> av_resp.readdata == 32'h0)
		else $error("command register read not zero");
	rdata_hold_a: assert property (!(av_req.read && wt) |=> $stable(av_resp.readdata))
		else $error("readdata moved without a read");

	// ==========================================================
	// Pulse outputs
	pps_start_a: assert property ($past(srst) |-> !pps_out ##1 pps_out)
		else $error("second pulse missing after reset");
	sid_osc_a: assert property (sidereal_pulse |-> osc_1mhz)
		else $error("sidereal pulse without oscillator edge");
	sid_burst_a: assert property (sidereal_pulse ##1 sidereal_pulse |=> !sidereal_pulse)
		else $error("more than one extra sidereal pulse");

	cover property (sidereal_pulse ##1 sidereal_pulse);
	cover property ($rose(ref_pps));
	cover property ($rose(pps_out));
	cover property (av_req.write && !wt);
endmodule

bind utc_modular_clock_core utc_clock_core_sva chk (.core_clk(core_clk), .srst(srst),
	.osc_1mhz(osc_1mhz), .ref_pps(ref_pps), .av_req(av_req), .av_resp(av_resp),
	.pps_out(pps_out), .sidereal_pulse(sidereal_pulse));
`default_nettype wire

// [dv/ref_link_model.sv]
// Far side: gated 1 MHz oscillator and reference second pulse over the link.
// Assumes a 40 MHz core_clk; fire is a one-cycle request from the bench.
`timescale 1ns/100ps
`default_nettype none

module ref_link_model #(
	parameter int HALF_CYC  = 20,
	parameter int PULSE_CYC = 40000
) (
	input  wire logic core_clk,
	input  wire logic osc_run,
	input  wire logic fire,
	output logic      osc_1mhz,
	output logic      ref_pps
);
	int   half_cnt  = 0;
	int   pulse_cnt = 0;
	logic osc_q     = 1'b0;

	assign osc_1mhz = osc_q;
	// Rising edge marks the second; line idles low between pulses
	assign ref_pps = (pulse_cnt != 0);

	always @(posedge core_clk) begin
		if (half_cnt == HALF_CYC - 1) begin
			half_cnt <= 0;
			// Stops only after a full high phase, so no runt edges
			if (osc_run || osc_q)
				osc_q <= !osc_q;
		end else
			half_cnt <= half_cnt + 1;
		// Link delay compensation is up to whoever times fire
		if (fire)
			pulse_cnt <= PULSE_CYC;
		else if (pulse_cnt != 0)
			pulse_cnt <= pulse_cnt - 1;
	end
endmodule
`default_nettype wire

// [dv/utc_modular_clock_core_test.sv]
// Self-checking bench for the clock core, driven over its register bus.
// Assumes the far-side model supplies oscillator and reference pulse.
`timescale 1ns/100ps
`default_nettype none

module utc_modular_clock_core_test;
	logic                      core_clk;
	logic                      srst;
	logic                      osc_run;
	logic                      fire;
	logic                      osc_1mhz;
	logic                      ref_pps;
	logic                      pps_out;
	logic                      sidereal_pulse;
	utc_clock_pkg::avmm_req_t  av_req;
	utc_clock_pkg::avmm_resp_t av_resp;
	int                        fails = 0;
	int                        n_compared = 0;
	int                        sid_cnt = 0;
	int                        sub;
	int                        s0;
	logic [31:0]               q;
	int                        step[5] = '{10000, 1000, 100, 10, 1};

	utc_modular_clock_core dut (.core_clk(core_clk), .srst(srst), .osc_1mhz(osc_1mhz),
		.ref_pps(ref_pps), .av_req(av_req), .av_resp(av_resp), .pps_out(pps_out),
		.sidereal_pulse(sidereal_pulse));
	// A short reference pulse keeps the run brief; only its rising edge counts
	ref_link_model #(.PULSE_CYC(200)) far (.core_clk(core_clk), .osc_run(osc_run),
		.fire(fire), .osc_1mhz(osc_1mhz), .ref_pps(ref_pps));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (sidereal_pulse === 1'b1)
			sid_cnt <= sid_cnt + 1;

	// ==========================================================
	// Tasks
	task automatic end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		av_req <= '{read: !wr, write: wr, address: a, writedata: d};
		do begin
			@(posedge core_clk);
			n++;
		end while (av_resp.waitrequest !== 1'b0 && n < 20);
		q = av_resp.readdata;
		av_req <= '0;
		if (n >= 20) begin
			fails++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(q, e);
	endtask
	task automatic run_osc(input int n);
		osc_run <= 1'b1;
		repeat (n * 40) @(posedge core_clk);
		osc_run <= 1'b0;
		repeat (40) @(posedge core_clk);
	endtask
	// Whole steps of 11111 then one 10 us step carry into the next second
	task automatic adv_sec;
		repeat (9) wr(utc_clock_pkg::REG_CMD, 32'h1f);
		wr(utc_clock_pkg::REG_CMD, 32'h10);
	endtask
	task automatic ref_pulse;
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
		repeat (250) @(posedge core_clk);
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		srst = 1'b1;
		av_req = '0;
		osc_run = 1'b0;
		fire = 1'b0;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rc(utc_clock_pkg::REG_RATE, 32'h38d);
		rc(utc_clock_pkg::REG_CTRL, 32'h0);
		rc(utc_clock_pkg::REG_CMD, 32'h0);
		rc(6'h3c, 32'h0);
		cmp(32'(pps_out), 32'h1);
		wr(utc_clock_pkg::REG_RATE, 32'h3e8);
		rc(utc_clock_pkg::REG_RATE, 32'h38d);
		wr(utc_clock_pkg::REG_RATE, 32'h3e7);
		rc(utc_clock_pkg::REG_RATE, 32'h3e7);
		wr(utc_clock_pkg::REG_RATE, 32'h38d);
		$display("test reset finished");

		run_osc(10);
		rc(utc_clock_pkg::REG_SUBSEC, 32'h1);
		wr(utc_clock_pkg::REG_CTRL, 32'h1);
		run_osc(10);
		rc(utc_clock_pkg::REG_SUBSEC, 32'h1);
		wr(utc_clock_pkg::REG_CTRL, 32'h0);
		$display("test tick finished");

		sub = 1;
		for (int i = 0; i < 5; i++) begin
			wr(utc_clock_pkg::REG_CMD, 32'h1 << i);
			sub += step[i];
			rc(utc_clock_pkg::REG_SUBSEC, 32'(sub));
		end
		cmp(32'(pps_out), 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(utc_clock_pkg::REG_CMD, 32'h20 << i);
			sub -= step[i];
			rc(utc_clock_pkg::REG_SUBSEC, 32'(sub));
		end
		repeat (2) wr(utc_clock_pkg::REG_CMD, 32'h200);
		rc(utc_clock_pkg::REG_SUBSEC, 32'h1869f);
		rc(utc_clock_pkg::REG_TIME, 32'h173b3b);
		rc(utc_clock_pkg::REG_DATE, 32'h16d);
		wr(utc_clock_pkg::REG_CMD, 32'h10);
		rc(utc_clock_pkg::REG_TIME, 32'h0);
		rc(utc_clock_pkg::REG_DATE, 32'h10000);
		$display("test steps finished");

		wr(utc_clock_pkg::REG_LEAP, 32'h1);
		wr(utc_clock_pkg::REG_SET_TIME, 32'h173b3b);
		wr(utc_clock_pkg::REG_SET_DAY, 32'h16e);
		wr(utc_clock_pkg::REG_CMD, 32'hc00);
		rc(utc_clock_pkg::REG_DATE, 32'h1016e);
		rc(utc_clock_pkg::REG_STATUS, 32'h4);
		adv_sec();
		rc(utc_clock_pkg::REG_DATE, 32'h20000);
		rc(utc_clock_pkg::REG_STATUS, 32'h0);
		wr(utc_clock_pkg::REG_LEAP, 32'h2);
		wr(utc_clock_pkg::REG_CMD, 32'h400);
		adv_sec();
		rc(utc_clock_pkg::REG_TIME, 32'h173b3c);
		adv_sec();
		rc(utc_clock_pkg::REG_TIME, 32'h0);
		rc(utc_clock_pkg::REG_DATE, 32'h20001);
		rc(utc_clock_pkg::REG_STATUS, 32'h0);
		repeat (8) wr(utc_clock_pkg::REG_CMD, 32'h1000);
		wr(utc_clock_pkg::REG_CMD, 32'h2000);
		rc(utc_clock_pkg::REG_DATE, 32'h100001);
		$display("test calendar finished");

		repeat (5) wr(utc_clock_pkg::REG_CMD, 32'h1);
		wr(utc_clock_pkg::REG_CTRL, 32'h2);
		ref_pulse();
		rc(utc_clock_pkg::REG_SUBSEC, 32'h0);
		rc(utc_clock_pkg::REG_TIME, 32'h1);
		rc(utc_clock_pkg::REG_STATUS, 32'h1);
		cmp(32'(pps_out), 32'h1);
		wr(utc_clock_pkg::REG_STATUS, 32'h1);
		rc(utc_clock_pkg::REG_STATUS, 32'h0);
		repeat (4) wr(utc_clock_pkg::REG_CMD, 32'h1);
		ref_pulse();
		rc(utc_clock_pkg::REG_TIME, 32'h1);
		rc(utc_clock_pkg::REG_SUBSEC, 32'h0);
		wr(utc_clock_pkg::REG_CTRL, 32'h0);
		$display("test sync finished");

		s0 = sid_cnt;
		run_osc(1000);
		cmp(32'(sid_cnt - s0), 32'd1002);
		$display("test sidereal finished");
		end_of_test();
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
